// *** hdl/otr_defines.svh ***
/*
 Constants for the output relay and thermal trip block.
 Assumes a 50 MHz clock and 8-bit APB byte addresses.
*/
`ifndef OTR_DEFINES_SVH
`define OTR_DEFINES_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define OTR_CLK_HZ 50000000
`define OTR_TICK_US 1000
`define OTR_TICK_CYC (`OTR_CLK_HZ / 1000000 * `OTR_TICK_US)
`define OTR_FLASH_MS 2000
`define OTR_FLASH_TICKS (`OTR_FLASH_MS * 1000 / `OTR_TICK_US)
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OTR_CTRL_OFS 8'h00
`define OTR_ASGN_OFS 8'h04
`define OTR_FULL_LOAD_OFS 8'h08
`define OTR_COOL_OFS 8'h0C
`define OTR_STAT_OFS 8'h10
`define OTR_HEAT_OFS 8'h14
`define OTR_FULL_OFS 8'h18
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define OTR_POL_LSB 0
`define OTR_LAT_LSB 4
`define OTR_SET_LSB 8
`define OTR_CSEL_BIT 16
`define OTR_PRE_LSB 0
`define OTR_LRN_LSB 8
`define OTR_POL_RST 4'h1
`define OTR_LAT_RST 4'h0
`define OTR_SET_RST 7'h00
`define OTR_ASGN_RST 32'h0000_0000
`define OTR_FULL_LOAD_RST 12'h064
`define OTR_PRE_RST 4'h8
`define OTR_LRN_RST 4'hA
`define OTR_FULL_PCT 7'h64
`define OTR_TRIP_IDX 0
`define OTR_AUX2_IDX 3
`endif

// *** hdl/otr_pkg.sv ***
/*
 Types for the output relay and thermal trip block.
 Assumes otr_defines.svh is on the include path.
*/
package otr_pkg;
    typedef enum logic [1:0] {
        APB_IDLE = 2'b01,
        APB_DONE = 2'b10
    } otr_apb_e;
    typedef logic [3:0] otr_relay_t;
endpackage

// *** hdl/otr_thermal.sv ***
/*
 Thermal memory: heat in units of percent times current.
 Assumes a one-cycle tick enable and synchronous current samples.
*/
`timescale 1ns/1ps
`include "otr_defines.svh"
module otr_thermal import otr_pkg::*; #(
    parameter int CW = 12,
    parameter int HW = 24
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic tick,
    input wire logic [CW-1:0] current,
    input wire logic [CW-1:0] fullLoadCurrent,
    input wire logic [6:0] setPct,
    input wire logic [3:0] coolShift,
    output logic [HW-1:0] heatReg,
    output logic [HW-1:0] fullReg,
    output logic tripReg
);
    logic [HW-1:0] target;
    logic [HW-1:0] diff;
    logic [HW-1:0] step;
    logic [HW:0] sum;
    logic [HW-1:0] heatNext;
    logic over;

    always_comb begin
        target = HW'(setPct * current);
        over = current > fullLoadCurrent;
        sum = {1'b0, heatReg} + (HW+1)'(current - fullLoadCurrent);
        diff = (heatReg > target) ? heatReg - target : target - heatReg;
        step = diff >> coolShift;
        if (step == '0) begin
            step = (diff != '0) ? HW'(1) : '0;
        end
        if (over) begin
            heatNext = sum[HW] ? '1 : sum[HW-1:0];
        end else if (heatReg > target) begin
            heatNext = heatReg - step;
        end else begin
            heatNext = heatReg + step;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            heatReg <= '0;
        end else if (tick) begin
            heatReg <= heatNext;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fullReg <= '0;
            tripReg <= 1'b0;
        end else begin
            fullReg <= HW'(`OTR_FULL_PCT * fullLoadCurrent);
            tripReg <= heatReg >= HW'(`OTR_FULL_PCT * fullLoadCurrent);
        end
    end

    decay_down_a: assert property (@(posedge clk) disable iff (srst)
        tick && !over && heatReg > target |=> heatReg < $past(heatReg))
        else $error("heat did not fall toward steady value");
endmodule

// *** hdl/otr_flash.sv ***
/*
 Flash message timer: holds the show flag for a fixed count of ticks.
 Assumes a one-cycle tick enable and a one-cycle start pulse.
*/
`timescale 1ns/1ps
`include "otr_defines.svh"
module otr_flash import otr_pkg::*; #(
    parameter int TICKS = `OTR_FLASH_TICKS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic tick,
    input wire logic start,
    output logic showReg
);
    logic [$clog2(TICKS+1)-1:0] cntReg;

    always_ff @(posedge clk) begin
        if (srst) begin
            cntReg <= '0;
            showReg <= 1'b0;
        end else if (start) begin
            cntReg <= ($clog2(TICKS+1))'(TICKS);
            showReg <= 1'b1;
        end else if (tick && cntReg != '0) begin
            cntReg <= cntReg - 1'b1;
            showReg <= cntReg != 1'b1;
        end
    end

    flash_load_a: assert property (@(posedge clk) disable iff (srst)
        start |=> showReg && cntReg == ($clog2(TICKS+1))'(TICKS))
        else $error("flash timer not loaded");
endmodule

// *** hdl/otr_top.sv ***
/*
 Output relay control and thermal trip, with an APB register file.
 Assumes protection conditions, reset inputs, power status and current
 are synchronous to clk; coil outputs drive the relay drivers.
*/
`timescale 1ns/1ps
`include "otr_defines.svh"
// Behaviour
// - Polarity per relay configurable; trip fail-safe default
// - Power loss drops every coil to unpowered
// - Steady heat equals setpoint times current fraction
// - After overload heat decays exponentially to steady
// - Settled heat shortens trip time by same share
// - Relay activates when any assigned condition asserts
// - Relay inactive when no assigned condition, unless latched
// - Latched relay holds until key or external reset
// - Trip and second auxiliary always latched
// - Unlatched relay clears once conditions clear
// - Fail-safe coil energized inactive, released active
// - Second auxiliary always fail-safe
// - Non-fail-safe coil energized only while active
// - Flash message shown fixed time then removed
// - Full thermal capacity raises overload trip
// - Cooling uses learned or preset rate
module otr_top import otr_pkg::*; #(
    parameter int CW = 12,
    parameter int HW = 24,
    parameter int TICK_CYC = `OTR_TICK_CYC,
    parameter int FLASH_TICKS = `OTR_FLASH_TICKS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [6:0] cond,
    input wire logic resetKey,
    input wire logic extReset,
    input wire logic powerOk,
    input wire logic [CW-1:0] current,
    input wire logic flashEvent,
    output otr_relay_t coil,
    output otr_relay_t relayActive,
    output logic overloadTrip,
    output logic flashShow
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    otr_apb_e stateReg;
    otr_relay_t polReg;
    otr_relay_t latReg;
    logic [6:0] setReg;
    logic coolSelReg;
    logic [31:0] asgnReg;
    logic [CW-1:0] fullLoadCurrentReg;
    logic [3:0] preReg;
    logic [3:0] lrnReg;
    logic [$clog2(TICK_CYC)-1:0] divReg;
    logic tickReg;
    otr_relay_t activeReg;
    otr_relay_t activeNext;
    otr_relay_t coilReg;
    otr_relay_t req;
    otr_relay_t latEff;
    otr_relay_t fsEff;
    logic [7:0] condAll;
    logic rstReq;
    logic [3:0] coolShift;
    logic [HW-1:0] heat;
    logic [HW-1:0] full;
    logic tripFlag;
    logic access;
    logic [31:0] rdMux;

    // Address decode, shared by read and write paths
    function automatic logic isReg(input logic [7:0] a, input logic [7:0] ofs);
        isReg = a == ofs;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = isReg(a, `OTR_CTRL_OFS) || isReg(a, `OTR_ASGN_OFS) ||
            isReg(a, `OTR_FULL_LOAD_OFS) || isReg(a, `OTR_COOL_OFS) ||
            isReg(a, `OTR_STAT_OFS) || isReg(a, `OTR_HEAT_OFS) ||
            isReg(a, `OTR_FULL_OFS);
    endfunction

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign access = psel && penable;

    always_ff @(posedge clk) begin
        if (srst) begin
            stateReg <= APB_IDLE;
        end else begin
            case (stateReg)
                APB_IDLE: begin
                    if (access) begin
                        stateReg <= APB_DONE;
                    end
                end
                APB_DONE: begin
                    stateReg <= APB_IDLE;
                end
                default: begin
                    stateReg <= APB_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        rdMux = '0;
        if (isReg(paddr, `OTR_CTRL_OFS)) begin
            rdMux[`OTR_POL_LSB +: 4] = polReg;
            rdMux[`OTR_LAT_LSB +: 4] = latReg;
            rdMux[`OTR_SET_LSB +: 7] = setReg;
            rdMux[`OTR_CSEL_BIT] = coolSelReg;
        end else if (isReg(paddr, `OTR_ASGN_OFS)) begin
            rdMux = asgnReg;
        end else if (isReg(paddr, `OTR_FULL_LOAD_OFS)) begin
            rdMux[CW-1:0] = fullLoadCurrentReg;
        end else if (isReg(paddr, `OTR_COOL_OFS)) begin
            rdMux[`OTR_PRE_LSB +: 4] = preReg;
            rdMux[`OTR_LRN_LSB +: 4] = lrnReg;
        end else if (isReg(paddr, `OTR_STAT_OFS)) begin
            rdMux[11:0] = {powerOk, flashShow, overloadTrip, 1'b0, coilReg, activeReg};
        end else if (isReg(paddr, `OTR_HEAT_OFS)) begin
            rdMux[HW-1:0] = heat;
        end else if (isReg(paddr, `OTR_FULL_OFS)) begin
            rdMux[HW-1:0] = full;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (stateReg == APB_IDLE && access) begin
            prdata <= pwrite ? 32'h0000_0000 : rdMux;
            pslverr <= !mapped(paddr);
        end else begin
            pslverr <= 1'b0;
        end
    end

    assign pready = stateReg[1];

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            polReg <= `OTR_POL_RST;
            latReg <= `OTR_LAT_RST;
            setReg <= `OTR_SET_RST;
            coolSelReg <= 1'b0;
        end else if (pready && access && pwrite && isReg(paddr, `OTR_CTRL_OFS)) begin
            polReg <= pwdata[`OTR_POL_LSB +: 4];
            latReg <= pwdata[`OTR_LAT_LSB +: 4];
            setReg <= pwdata[`OTR_SET_LSB +: 7];
            coolSelReg <= pwdata[`OTR_CSEL_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            asgnReg <= `OTR_ASGN_RST;
        end else if (pready && access && pwrite && isReg(paddr, `OTR_ASGN_OFS)) begin
            asgnReg <= pwdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fullLoadCurrentReg <= `OTR_FULL_LOAD_RST;
        end else if (pready && access && pwrite && isReg(paddr, `OTR_FULL_LOAD_OFS)) begin
            fullLoadCurrentReg <= pwdata[CW-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            preReg <= `OTR_PRE_RST;
            lrnReg <= `OTR_LRN_RST;
        end else if (pready && access && pwrite && isReg(paddr, `OTR_COOL_OFS)) begin
            preReg <= pwdata[`OTR_PRE_LSB +: 4];
            lrnReg <= pwdata[`OTR_LRN_LSB +: 4];
        end
    end

    // ----------------------------------------
    // Millisecond tick
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            divReg <= '0;
            tickReg <= 1'b0;
        end else begin
            tickReg <= divReg == ($clog2(TICK_CYC))'(TICK_CYC - 1);
            divReg <= (divReg == ($clog2(TICK_CYC))'(TICK_CYC - 1)) ? '0 : divReg + 1'b1;
        end
    end

    // ----------------------------------------
    // Thermal model and flash timer
    // ----------------------------------------
    assign coolShift = coolSelReg ? lrnReg : preReg;

    otr_thermal #(
        .CW(CW),
        .HW(HW)
    ) thermal (
        .clk(clk),
        .srst(srst),
        .tick(tickReg),
        .current(current),
        .fullLoadCurrent(fullLoadCurrentReg),
        .setPct(setReg),
        .coolShift(coolShift),
        .heatReg(heat),
        .fullReg(full),
        .tripReg(tripFlag)
    );

    otr_flash #(
        .TICKS(FLASH_TICKS)
    ) flash (
        .clk(clk),
        .srst(srst),
        .tick(tickReg),
        .start(flashEvent),
        .showReg(flashShow)
    );

    assign overloadTrip = tripFlag;

    // ----------------------------------------
    // Output relays
    // ----------------------------------------
    assign condAll = {tripFlag, cond};
    assign rstReq = resetKey || extReset;

    for (genvar i = 0; i < 4; i++) begin : g_relay
        assign req[i] = |(asgnReg[8*i +: 8] & condAll);
        assign latEff[i] = latReg[i] || i == `OTR_TRIP_IDX || i == `OTR_AUX2_IDX;
        assign fsEff[i] = polReg[i] || i == `OTR_AUX2_IDX;
        // Reset cannot clear while a condition holds the request
        assign activeNext[i] = req[i] || (latEff[i] && activeReg[i] && !rstReq);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            activeReg <= '0;
        end else begin
            activeReg <= activeNext;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            coilReg <= '0;
        end else if (!powerOk) begin
            coilReg <= '0;
        end else begin
            coilReg <= activeReg ^ fsEff;
        end
    end

    assign coil = coilReg;
    assign relayActive = activeReg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    pol_default_a: assert property (@(posedge clk)
        srst |=> polReg == `OTR_POL_RST)
        else $error("trip not fail-safe after reset");

    coil_unpowered_a: assert property (@(posedge clk) disable iff (srst)
        !powerOk |=> coil == '0)
        else $error("coil energized without control power");

    relay_activate_a: assert property (@(posedge clk) disable iff (srst)
        req[1] |=> relayActive[1])
        else $error("assigned condition did not activate relay");

    trip_latched_a: assert property (@(posedge clk) disable iff (srst)
        relayActive[0] && !rstReq |=> relayActive[0])
        else $error("trip relay released without reset");

    aux2_latched_a: assert property (@(posedge clk) disable iff (srst)
        relayActive[3] && !rstReq ##1 !rstReq |=> relayActive[3])
        else $error("second auxiliary not latched");

    unlatch_clear_a: assert property (@(posedge clk) disable iff (srst)
        !latReg[1] && !req[1] |=> !relayActive[1])
        else $error("unlatched relay did not clear");

    coil_polarity_a: assert property (@(posedge clk) disable iff (srst)
        powerOk |=> coil == ($past(relayActive) ^ $past(fsEff)))
        else $error("coil polarity wrong");

    aux2_failsafe_a: assert property (@(posedge clk) disable iff (srst)
        powerOk && !relayActive[3] |=> coil[3])
        else $error("second auxiliary not fail-safe");

    nonfs_idle_a: assert property (@(posedge clk) disable iff (srst)
        !polReg[2] && !relayActive[2] |=> !coil[2])
        else $error("non-fail-safe coil energized while inactive");

    reset_blocked_a: assert property (@(posedge clk) disable iff (srst)
        rstReq && req[0] |=> relayActive[0])
        else $error("reset cleared relay with live condition");

    overload_trip_a: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) && heat >= full && $stable(fullLoadCurrentReg) |=> overloadTrip)
        else $error("full thermal capacity without trip");

    trip_cov: cover property (@(posedge clk) disable iff (srst)
        $rose(overloadTrip));
    reset_cov: cover property (@(posedge clk) disable iff (srst)
        relayActive[0] && rstReq ##1 !relayActive[0]);
    power_cov: cover property (@(posedge clk) disable iff (srst)
        $fell(powerOk) && relayActive != '0);
    flash_cov: cover property (@(posedge clk) disable iff (srst)
        $fell(flashShow));
endmodule

// *** dv/otr_starter.sv ***
/*
 Motor starter model worked by the trip relay contact.
 Assumes the trip coil polarity is given by tripFs.
*/
`timescale 1ns/1ps
module otr_starter #(
    parameter int DELAY = 3
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic coilIn,
    input wire logic tripFs,
    output logic running
);
    int cnt;
    // ----------------
    // Drop out once the contact has stayed active
    // ----------------
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt <= 0;
            running <= 1'b1;
        end else if ((tripFs ? !coilIn : coilIn) && cnt < DELAY) begin
            cnt <= cnt + 1;
        end else if (cnt == DELAY) begin
            running <= 1'b0;
        end else begin
            cnt <= 0;
        end
    end
endmodule

// *** dv/otr_top_tb.sv ***
/*
 Self-checking bench for the relay and thermal trip block.
 Assumes short tick and flash counts and a starter model on trip.
*/
`timescale 1ns/1ps
module otr_top_tb import otr_pkg::*;;
    typedef struct {
        logic [31:0] ctrl;
        logic [6:0] cnd;
        otr_relay_t act;
        otr_relay_t cl;
    } otr_row_s;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er;
    logic [6:0] cond = 7'h00;
    logic resetKey = 1'b0, extReset = 1'b0, powerOk = 1'b1, flashEvent = 1'b0;
    logic [11:0] current = 12'h000;
    otr_relay_t coil, relayActive;
    logic overloadTrip, flashShow, running;
    int badCount = 0;
    int nChecks = 0;
    int n;
    otr_row_s rows[8] = '{'{32'h01, 7'h00, 4'h0, 4'h9}, '{32'h01, 7'h02, 4'h2, 4'hB},
        '{32'h01, 7'h24, 4'h6, 4'hF}, '{32'h07, 7'h04, 4'h4, 4'hB}, '{32'h06, 7'h00, 4'h0, 4'hE},
        '{32'h00, 7'h00, 4'h0, 4'h8}, '{32'h00, 7'h02, 4'h2, 4'hA}, '{32'h00, 7'h00, 4'h0, 4'h8}};

    always #10 clk = ~clk;

    otr_top #(.TICK_CYC(4), .FLASH_TICKS(5)) u_otr_top (.clk(clk), .srst(srst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cond(cond), .resetKey(resetKey), .extReset(extReset),
        .powerOk(powerOk), .current(current), .flashEvent(flashEvent), .coil(coil),
        .relayActive(relayActive), .overloadTrip(overloadTrip), .flashShow(flashShow));
    otr_starter #(.DELAY(3)) u_otr_starter (.clk(clk), .srst(srst), .coilIn(coil[0]),
        .tripFs(1'b1), .running(running));

    // ----------------
    // Shared tasks
    // ----------------
    task automatic finishTest;
        if (badCount == 0 && nChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
            badCount++;
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(nm, exp, rd);
    endtask

    // ----------------
    // Watchdog
    // ----------------
    initial begin
        #400000;
        badCount++;
        finishTest();
    end

    // ----------------
    // Main sequence
    // ----------------
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("coil", 32'h9, coil);
        chk("running", 32'h1, running);
        rdchk("ctrl", 8'h00, 32'h1);
        rdchk("cool", 8'h0C, 32'hA08);
        apb(8'h1C, 1'b0, 32'h0);
        chk("err", 32'h1, er);
        apb(8'h10, 1'b1, 32'hFFFF_FFFF);
        rdchk("stat", 8'h10, 32'h890);
        apb(8'h04, 1'b1, 32'h0804_2281);
        for (int i = 0; i < 8; i++) begin
            apb(8'h00, 1'b1, rows[i].ctrl);
            cond <= rows[i].cnd;
            repeat (3) @(posedge clk);
            chk("active", rows[i].act, relayActive);
            chk("coil", rows[i].cl, coil);
        end
        apb(8'h00, 1'b1, 32'h21);
        cond <= 7'h01;
        repeat (3) @(posedge clk);
        cond <= 7'h00;
        repeat (6) @(posedge clk);
        chk("trip", 32'h1, relayActive[0]);
        chk("running", 32'h0, running);
        cond <= 7'h01;
        resetKey <= 1'b1;
        repeat (3) @(posedge clk);
        chk("trip", 32'h1, relayActive[0]);
        cond <= 7'h00;
        repeat (3) @(posedge clk);
        chk("trip", 32'h0, relayActive[0]);
        chk("coil", 32'h9, coil);
        resetKey <= 1'b0;
        cond <= 7'h0A;
        repeat (3) @(posedge clk);
        cond <= 7'h00;
        repeat (3) @(posedge clk);
        chk("active", 32'hA, relayActive);
        chk("coil", 32'h3, coil);
        powerOk <= 1'b0;
        repeat (3) @(posedge clk);
        chk("coil", 32'h0, coil);
        powerOk <= 1'b1;
        extReset <= 1'b1;
        repeat (3) @(posedge clk);
        chk("active", 32'h0, relayActive);
        extReset <= 1'b0;
        apb(8'h00, 1'b1, 32'h1E01);
        apb(8'h0C, 1'b1, 32'hA01);
        current <= 12'd100;
        repeat (200) @(posedge clk);
        rdchk("heat", 8'h14, 32'd3000);
        current <= 12'd50;
        repeat (200) @(posedge clk);
        rdchk("heat", 8'h14, 32'd1500);
        rdchk("full", 8'h18, 32'd10000);
        current <= 12'd100;
        repeat (200) @(posedge clk);
        current <= 12'd150;
        n = 0;
        while (overloadTrip !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk("tripTime", 32'h1, n >= 550 && n <= 570);
        repeat (3) @(posedge clk);
        chk("trip", 32'h1, relayActive[0]);
        current <= 12'd0;
        apb(8'h0C, 1'b1, 32'h10F);
        apb(8'h00, 1'b1, 32'h11E01);
        repeat (200) @(posedge clk);
        rdchk("heat", 8'h14, 32'd0);
        chk("ovl", 32'h0, overloadTrip);
        apb(8'h00, 1'b1, 32'h1E01);
        current <= 12'd100;
        repeat (200) @(posedge clk);
        apb(8'h14, 1'b0, 32'h0);
        chk("slowHeat", 32'h1, rd >= 40 && rd <= 60);
        flashEvent <= 1'b1;
        @(posedge clk);
        flashEvent <= 1'b0;
        repeat (12) @(posedge clk);
        chk("flash", 32'h1, flashShow);
        repeat (16) @(posedge clk);
        chk("flash", 32'h0, flashShow);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("active", 32'h0, relayActive);
        chk("coil", 32'h9, coil);
        finishTest();
    end
endmodule
